//--- core/ifsr_pkg.sv
// Function
// RULE1: received flow field: 00 none, 01 pause seen, 10 resume seen, 11 both.
// RULE2: reading the flow status register clears its upper four bits.
// RULE3: received flow field holds its value until software reads status.
// RULE4: received flow field updates on pattern regardless of mode or mask bits.
// RULE5: auto-sent field shows last auto-sent flow char; 00 when mode off. Code ORs each sent char in until a status read, so both give 11.
// RULE6: clearing auto-receiver flow enable forces the auto-sent field to 00.
// RULE7: host must send resume itself if leaving auto mode after pause sent.
// RULE8: transmitter flow field: 00 normal, 01 halt pending, 10 restarted, 11 halted.
// RULE9: pending halt waits for current character to finish, then shows 11.
// RULE10: after restarted shown, a status read returns the field to 00.
// RULE11: transmitter flow field reads 11 while stopped by received pause.
// RULE12: transmit type field reads 00 when no automatic flow control enabled.
// RULE13: type 01 while waiting for queue data, one bit time unless empty.
// RULE14: type 10 pause pending, 11 resume pending, at most one character time.
// RULE15: recognition enable register has paired disable/enable bits; zero does nothing.
// RULE16: enable and disable written together means disable.
// RULE17: recognition enables start no automatic flow or wake-up actions.
// RULE18: each recognition event is reported in the interrupt status register.
// RULE19: watchdog enable is one state shared with mode register zero bit 7.
// RULE20: resume compare char resets to 11 hex and is used for resume detection.
// RULE21: pause compare char resets to 13 hex and is used for pause detection.
// RULE22: detection is full eight-bit compare, once per received character.
package ifsr_pkg;
  localparam logic [11:0] ADDR_FLOW_STATUS = 12'h000;
  localparam logic [11:0] ADDR_RECOG_ENABLE = 12'h004;
  localparam logic [11:0] ADDR_MODE_ZERO = 12'h008;
  localparam logic [11:0] ADDR_MODE_THREE = 12'h00C;
  localparam logic [11:0] ADDR_RESUME_CHAR = 12'h010;
  localparam logic [11:0] ADDR_PAUSE_CHAR = 12'h014;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h018;
  localparam logic [7:0] RESUME_CHAR_RESET = 8'h11;
  localparam logic [7:0] PAUSE_CHAR_RESET = 8'h13;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int WD_DIS_BIT = 7;
  localparam int WD_EN_BIT = 6;
  localparam int AR_DIS_BIT = 5;
  localparam int AR_EN_BIT = 4;
  localparam int XON_DIS_BIT = 3;
  localparam int XON_EN_BIT = 2;
  localparam int XOFF_DIS_BIT = 1;
  localparam int XOFF_EN_BIT = 0;
  localparam int MR0_WD_BIT = 7;
  localparam int MR0_AUTORX_BIT = 3;
  localparam logic [1:0] RX_NONE = 2'h0;
  localparam logic [1:0] RX_PAUSE = 2'h1;
  localparam logic [1:0] RX_RESUME = 2'h2;
  localparam logic [1:0] AUTO_RESUME = 2'h1;
  localparam logic [1:0] AUTO_PAUSE = 2'h2;
  localparam logic [1:0] TXF_NORMAL = 2'h0;
  localparam logic [1:0] TXF_PENDING = 2'h1;
  localparam logic [1:0] TXF_RESTART = 2'h2;
  localparam logic [1:0] TXF_HALTED = 2'h3;
  localparam logic [1:0] TXT_DATA = 2'h0;
  localparam logic [1:0] TXT_IDLE = 2'h1;
  localparam logic [1:0] TXT_PAUSE = 2'h2;
  localparam logic [1:0] TXT_RESUME = 2'h3;
  localparam int IS_RESUME_BIT = 0;
  localparam int IS_PAUSE_BIT = 1;
  localparam int IS_ADDR_BIT = 2;

  typedef enum logic [3:0] {
    TXF_ST_NORMAL = 4'h1,
    TXF_ST_PENDING = 4'h2,
    TXF_ST_HALTED = 4'h4,
    TXF_ST_RESTART = 4'h8
  } ifsr_txflow_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ifsr_rxchar_type;

  typedef struct packed {
    logic charDone;
    logic sentResume;
    logic sentPause;
    logic bitTick;
    logic queueEmpty;
    logic pauseCmd;
    logic resumeCmd;
  } ifsr_txev_type;

  typedef struct packed {
    logic [7:0] rxFlow;
    logic [7:0] recog;
    logic [7:0] modeZero;
    logic [7:0] modeThree;
    logic [7:0] resumeChar;
    logic [7:0] pauseChar;
    logic [7:0] intStatus;
    ifsr_txflow_type txFlow;
    logic [1:0] txType;
    logic [31:0] prdata;
    logic pready;
    logic txHalt;
  } ifsr_state_type;
endpackage

//--- core/ifsr_top.sv
`timescale 1ns/1ps
module ifsr_top
  import ifsr_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel events, same clock
  input ifsr_rxchar_type rxChar,
  input ifsr_txev_type txEv,
  // controls to channel
  output logic txHalt,
  output logic watchdogEn,
  output logic addrMatchEn,
  output logic autoRxFlowEn
);
  ifsr_state_type s_q, s_d;
  logic acc, rdStatus;
  logic resumeHit, pauseHit;
  logic [7:0] wb;
  logic [7:0] flowStatus;
  logic txQuiet;
  assign txQuiet = !(txEv.pauseCmd || txEv.resumeCmd || txEv.sentPause || txEv.sentResume);

  assign acc = psel && penable && !s_q.pready;
  assign wb = pwdata[7:0];
  assign rdStatus = acc && !pwrite && paddr == ADDR_FLOW_STATUS;
  // only the recognition enables gate detection; auto modes do not [RULE4]
  assign resumeHit = rxChar.valid && s_q.recog[XON_EN_BIT] && rxChar.data == s_q.resumeChar; // [RULE20] [RULE22]
  assign pauseHit = rxChar.valid && s_q.recog[XOFF_EN_BIT] && rxChar.data == s_q.pauseChar; // [RULE21] [RULE22]

  always_comb begin
    flowStatus[7:6] = s_q.rxFlow[1:0];
    flowStatus[5:4] = s_q.modeZero[MR0_AUTORX_BIT] ? s_q.rxFlow[3:2] : 2'h0; // [RULE5]
    case (s_q.txFlow) // [RULE8]
      TXF_ST_NORMAL: flowStatus[3:2] = TXF_NORMAL;
      TXF_ST_PENDING: flowStatus[3:2] = TXF_PENDING;
      TXF_ST_HALTED: flowStatus[3:2] = TXF_HALTED; // [RULE11]
      TXF_ST_RESTART: flowStatus[3:2] = TXF_RESTART;
      default: flowStatus[3:2] = TXF_NORMAL;
    endcase
    flowStatus[1:0] = (s_q.modeThree[3:2] == 2'h0) ? TXT_DATA : s_q.txType; // [RULE12]
  end

  always_comb begin
    s_d = s_q;
    s_d.pready = acc;
    s_d.prdata = 32'h0;
    // register writes
    if (acc && pwrite) begin
      case (paddr)
        ADDR_RECOG_ENABLE: begin
          // disable wins when both set; zero bits do nothing [RULE15] [RULE16]
          if (wb[WD_EN_BIT]) s_d.modeZero[MR0_WD_BIT] = 1'b1;
          if (wb[WD_DIS_BIT]) s_d.modeZero[MR0_WD_BIT] = 1'b0; // [RULE19]
          if (wb[AR_EN_BIT]) s_d.recog[AR_EN_BIT] = 1'b1;
          if (wb[AR_DIS_BIT]) s_d.recog[AR_EN_BIT] = 1'b0;
          if (wb[XON_EN_BIT]) s_d.recog[XON_EN_BIT] = 1'b1;
          if (wb[XON_DIS_BIT]) s_d.recog[XON_EN_BIT] = 1'b0;
          if (wb[XOFF_EN_BIT]) s_d.recog[XOFF_EN_BIT] = 1'b1;
          if (wb[XOFF_DIS_BIT]) s_d.recog[XOFF_EN_BIT] = 1'b0;
          // only mode zero bit 7 (watchdog) is touched, so no auto flow or wake-up starts [RULE17]
        end
        ADDR_MODE_ZERO: s_d.modeZero = wb; // [RULE19]
        ADDR_MODE_THREE: s_d.modeThree = wb;
        ADDR_RESUME_CHAR: s_d.resumeChar = wb;
        ADDR_PAUSE_CHAR: s_d.pauseChar = wb;
        ADDR_INT_STATUS: s_d.intStatus = s_q.intStatus & ~wb;
        default: ;
      endcase
    end
    // register reads
    if (acc && !pwrite) begin
      case (paddr)
        ADDR_FLOW_STATUS: s_d.prdata = {24'h0, flowStatus};
        ADDR_MODE_ZERO: s_d.prdata = {24'h0, s_q.modeZero};
        ADDR_MODE_THREE: s_d.prdata = {24'h0, s_q.modeThree};
        ADDR_RESUME_CHAR: s_d.prdata = {24'h0, s_q.resumeChar};
        ADDR_PAUSE_CHAR: s_d.prdata = {24'h0, s_q.pauseChar};
        ADDR_INT_STATUS: s_d.prdata = {24'h0, s_q.intStatus};
        default: s_d.prdata = 32'h0;
      endcase
    end
    // a status read clears upper bits; new events in same cycle still land [RULE2] [RULE3]
    if (rdStatus) s_d.rxFlow[3:0] = 4'h0;
    if (resumeHit) s_d.rxFlow[1:0] = s_d.rxFlow[1:0] | RX_RESUME; // [RULE1] [RULE4]
    if (pauseHit) s_d.rxFlow[1:0] = s_d.rxFlow[1:0] | RX_PAUSE; // [RULE1]
    if (s_q.modeZero[MR0_AUTORX_BIT]) begin
      if (txEv.sentResume) s_d.rxFlow[3:2] = s_d.rxFlow[3:2] | AUTO_RESUME; // [RULE5]
      if (txEv.sentPause) s_d.rxFlow[3:2] = s_d.rxFlow[3:2] | AUTO_PAUSE;
    end
    if (!s_d.modeZero[MR0_AUTORX_BIT]) s_d.rxFlow[3:2] = 2'h0; // [RULE6]
    // recognition events are sticky, set wins over clear [RULE18]
    if (resumeHit) s_d.intStatus[IS_RESUME_BIT] = 1'b1;
    if (pauseHit) s_d.intStatus[IS_PAUSE_BIT] = 1'b1;
    if (rxChar.valid && s_q.recog[AR_EN_BIT] && rxChar.data == 8'h00) s_d.intStatus[IS_ADDR_BIT] = 1'b1;
    // transmitter flow, driven only when auto transmit flow (mode three bit 7) on
    case (s_q.txFlow)
      TXF_ST_NORMAL: if (pauseHit && s_q.modeThree[7]) s_d.txFlow = TXF_ST_PENDING;
      TXF_ST_PENDING: begin
        if (resumeHit) s_d.txFlow = TXF_ST_NORMAL;
        else if (txEv.charDone) s_d.txFlow = TXF_ST_HALTED; // [RULE9]
      end
      TXF_ST_HALTED: if (resumeHit) s_d.txFlow = TXF_ST_RESTART;
      TXF_ST_RESTART: begin
        if (pauseHit && s_q.modeThree[7]) s_d.txFlow = TXF_ST_PENDING;
        else if (rdStatus) s_d.txFlow = TXF_ST_NORMAL; // [RULE10]
      end
      default: s_d.txFlow = TXF_ST_NORMAL;
    endcase
    if (!s_q.modeThree[7]) s_d.txFlow = TXF_ST_NORMAL;
    s_d.txHalt = (s_d.txFlow == TXF_ST_HALTED); // [RULE11]
    // transmit character type [RULE13] [RULE14]
    if (txEv.pauseCmd) s_d.txType = TXT_PAUSE;
    else if (txEv.resumeCmd) s_d.txType = TXT_RESUME;
    else if (txEv.sentPause || txEv.sentResume) s_d.txType = TXT_IDLE;
    else if (s_q.txType == TXT_IDLE && txEv.bitTick && !txEv.queueEmpty) s_d.txType = TXT_DATA;
    else if ((s_q.txType == TXT_PAUSE || s_q.txType == TXT_RESUME) && txEv.charDone) s_d.txType = TXT_IDLE;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{rxFlow: 8'h00, recog: 8'h00, modeZero: MODE_RESET, modeThree: MODE_RESET,
               resumeChar: RESUME_CHAR_RESET, pauseChar: PAUSE_CHAR_RESET, intStatus: 8'h00,
               txFlow: TXF_ST_NORMAL, txType: TXT_DATA, prdata: 32'h0, pready: 1'b0, txHalt: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdogEn <= 1'b0;
      addrMatchEn <= 1'b0;
      autoRxFlowEn <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      watchdogEn <= s_d.modeZero[MR0_WD_BIT];
      addrMatchEn <= s_d.recog[AR_EN_BIT];
      autoRxFlowEn <= s_d.modeZero[MR0_AUTORX_BIT];
      pslverr <= 1'b0;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign txHalt = s_q.txHalt;

  resume_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> s_q.resumeChar == 8'h11) else $error("resume char reset wrong"); // [RULE20]
  both_wins_a: assert property (@(posedge clk) disable iff (!nrst)
    (acc && pwrite && paddr == ADDR_RECOG_ENABLE && wb[XON_EN_BIT] && wb[XON_DIS_BIT])
    |=> !s_q.recog[XON_EN_BIT]) else $error("disable did not win"); // [RULE16]
  read_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (rdStatus && !resumeHit && !pauseHit) |=> s_q.rxFlow[1:0] == 2'h0) else $error("read did not clear"); // [RULE2]
  rx_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (!rdStatus && !resumeHit && !pauseHit) |=> s_q.rxFlow[1:0] == $past(s_q.rxFlow[1:0]))
    else $error("rx field changed"); // [RULE3]
  pause_seen_a: assert property (@(posedge clk) disable iff (!nrst)
    pauseHit |=> s_q.rxFlow[0]) else $error("pause not recorded"); // [RULE1]
  auto_off_a: assert property (@(posedge clk) disable iff (!nrst)
    !s_q.modeZero[MR0_AUTORX_BIT] |-> flowStatus[5:4] == 2'h0) else $error("auto field not zero"); // [RULE6]
  halt_after_a: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.txFlow == TXF_ST_PENDING && txEv.charDone && !resumeHit && s_q.modeThree[7])
    |=> s_q.txFlow == TXF_ST_HALTED && txHalt) else $error("halt not taken"); // [RULE9]
  type_off_a: assert property (@(posedge clk) disable iff (!nrst)
    s_q.modeThree[3:2] == 2'h0 |-> flowStatus[1:0] == 2'h0) else $error("type not zero"); // [RULE12]
  restart_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.txFlow == TXF_ST_RESTART && rdStatus && !pauseHit && s_q.modeThree[7])
    |=> s_q.txFlow == TXF_ST_NORMAL) else $error("restart not cleared"); // [RULE10]

  pause_reset_a: assert property ( // [RULE21]
    @(posedge clk) disable iff (!nrst)
    $rose(nrst)
    |-> s_q.pauseChar == 8'h13)
    else $error("pause char reset wrong");

  resume_seen_a: assert property ( // [RULE1]
    @(posedge clk) disable iff (!nrst)
    resumeHit
    |=> s_q.rxFlow[1])
    else $error("resume not recorded");

  pause_int_a: assert property ( // [RULE18]
    @(posedge clk) disable iff (!nrst)
    pauseHit
    |=> s_q.intStatus[IS_PAUSE_BIT])
    else $error("pause event not reported");

  resume_int_a: assert property ( // [RULE18]
    @(posedge clk) disable iff (!nrst)
    resumeHit
    |=> s_q.intStatus[IS_RESUME_BIT])
    else $error("resume event not reported");

  addr_int_a: assert property ( // [RULE18]
    @(posedge clk) disable iff (!nrst)
    rxChar.valid && s_q.recog[AR_EN_BIT] && rxChar.data == 8'h00
    |=> s_q.intStatus[IS_ADDR_BIT])
    else $error("address event not reported");

  auto_zero_a: assert property ( // [RULE6]
    @(posedge clk) disable iff (!nrst)
    !s_q.modeZero[MR0_AUTORX_BIT]
    |-> s_q.rxFlow[3:2] == 2'h0)
    else $error("auto field kept while off");

  auto_pause_a: assert property ( // [RULE5]
    @(posedge clk) disable iff (!nrst)
    s_q.modeZero[MR0_AUTORX_BIT] && txEv.sentPause && !(acc && pwrite && paddr == ADDR_MODE_ZERO)
    |=> s_q.rxFlow[3])
    else $error("auto pause not shown");

  auto_resume_a: assert property ( // [RULE5]
    @(posedge clk) disable iff (!nrst)
    s_q.modeZero[MR0_AUTORX_BIT] && txEv.sentResume && !(acc && pwrite && paddr == ADDR_MODE_ZERO)
    |=> s_q.rxFlow[2])
    else $error("auto resume not shown");

  auto_read_a: assert property ( // [RULE2]
    @(posedge clk) disable iff (!nrst)
    rdStatus && !txEv.sentPause && !txEv.sentResume
    |=> s_q.rxFlow[3:2] == 2'h0)
    else $error("auto field not cleared by read");

  resume_match_a: assert property ( // [RULE22]
    @(posedge clk) disable iff (!nrst)
    rxChar.data != s_q.resumeChar && !rdStatus
    |=> s_q.rxFlow[1] == $past(s_q.rxFlow[1]))
    else $error("resume seen without match");

  pause_match_a: assert property ( // [RULE22]
    @(posedge clk) disable iff (!nrst)
    rxChar.data != s_q.pauseChar && !rdStatus
    |=> s_q.rxFlow[0] == $past(s_q.rxFlow[0]))
    else $error("pause seen without match");

  halt_level_a: assert property ( // [RULE11]
    @(posedge clk) disable iff (!nrst)
    s_q.txFlow == TXF_ST_HALTED
    |-> txHalt)
    else $error("halted without halt output");

  halt_clear_a: assert property ( // [RULE11]
    @(posedge clk) disable iff (!nrst)
    s_q.txFlow != TXF_ST_HALTED
    |-> !txHalt)
    else $error("halt output while not halted");

  halt_hold_a: assert property ( // [RULE11]
    @(posedge clk) disable iff (!nrst)
    s_q.txFlow == TXF_ST_HALTED && !resumeHit && s_q.modeThree[7]
    |=> s_q.txFlow == TXF_ST_HALTED)
    else $error("halt left without resume");

  pend_entry_a: assert property ( // [RULE8]
    @(posedge clk) disable iff (!nrst)
    s_q.txFlow == TXF_ST_NORMAL && pauseHit && s_q.modeThree[7]
    |=> s_q.txFlow == TXF_ST_PENDING)
    else $error("halt not pending");

  pend_cancel_a: assert property ( // [RULE8]
    @(posedge clk) disable iff (!nrst)
    s_q.txFlow == TXF_ST_PENDING && resumeHit && s_q.modeThree[7]
    |=> s_q.txFlow == TXF_ST_NORMAL)
    else $error("pending halt not cancelled");

  restart_entry_a: assert property ( // [RULE8]
    @(posedge clk) disable iff (!nrst)
    s_q.txFlow == TXF_ST_HALTED && resumeHit && s_q.modeThree[7]
    |=> s_q.txFlow == TXF_ST_RESTART)
    else $error("restart not shown");

  restart_hold_a: assert property ( // [RULE10]
    @(posedge clk) disable iff (!nrst)
    s_q.txFlow == TXF_ST_RESTART && !rdStatus && !pauseHit && s_q.modeThree[7]
    |=> s_q.txFlow == TXF_ST_RESTART)
    else $error("restart lost without read");

  flow_off_a: assert property ( // [RULE8]
    @(posedge clk) disable iff (!nrst)
    !s_q.modeThree[7]
    |=> s_q.txFlow == TXF_ST_NORMAL)
    else $error("flow state active while off");

  type_pause_a: assert property ( // [RULE14]
    @(posedge clk) disable iff (!nrst)
    txEv.pauseCmd
    |=> s_q.txType == TXT_PAUSE)
    else $error("pause pending not shown");

  type_resume_a: assert property ( // [RULE14]
    @(posedge clk) disable iff (!nrst)
    txEv.resumeCmd && !txEv.pauseCmd
    |=> s_q.txType == TXT_RESUME)
    else $error("resume pending not shown");

  type_idle_a: assert property ( // [RULE13]
    @(posedge clk) disable iff (!nrst)
    (txEv.sentPause || txEv.sentResume) && !txEv.pauseCmd && !txEv.resumeCmd
    |=> s_q.txType == TXT_IDLE)
    else $error("idle wait not shown");

  type_leave_a: assert property ( // [RULE14]
    @(posedge clk) disable iff (!nrst)
    s_q.txType[1] && txEv.charDone && txQuiet
    |=> s_q.txType == TXT_IDLE)
    else $error("pending code outlived character");

  idle_end_a: assert property ( // [RULE13]
    @(posedge clk) disable iff (!nrst)
    s_q.txType == TXT_IDLE && txEv.bitTick && !txEv.queueEmpty && txQuiet
    |=> s_q.txType == TXT_DATA)
    else $error("idle wait outlived bit time");

  wd_enable_a: assert property ( // [RULE19]
    @(posedge clk) disable iff (!nrst)
    acc && pwrite && paddr == ADDR_RECOG_ENABLE && wb[WD_EN_BIT] && !wb[WD_DIS_BIT]
    |=> watchdogEn)
    else $error("watchdog not enabled");

  wd_disable_a: assert property ( // [RULE16]
    @(posedge clk) disable iff (!nrst)
    acc && pwrite && paddr == ADDR_RECOG_ENABLE && wb[WD_DIS_BIT]
    |=> !watchdogEn)
    else $error("watchdog not disabled");

  zero_write_a: assert property ( // [RULE15]
    @(posedge clk) disable iff (!nrst)
    acc && pwrite && paddr == ADDR_RECOG_ENABLE && wb == 8'h00
    |=> s_q.recog == $past(s_q.recog) && s_q.modeZero == $past(s_q.modeZero))
    else $error("zero write changed enables");

  recog_mode_a: assert property ( // [RULE17]
    @(posedge clk) disable iff (!nrst)
    acc && pwrite && paddr == ADDR_RECOG_ENABLE
    |=> s_q.modeThree == $past(s_q.modeThree) && autoRxFlowEn == $past(autoRxFlowEn))
    else $error("enable write started flow");

  answer_a: assert property (
    @(posedge clk) disable iff (!nrst)
    acc
    |=> pready)
    else $error("access not answered");
endmodule

//--- sim/ifsr_partner.sv
`timescale 1ns/1ps
module ifsr_partner
  import ifsr_pkg::*;
(
  // system
  input wire logic clk,
  // toward the block
  output ifsr_rxchar_type rxChar,
  output ifsr_txev_type txEv
);
  initial begin
    rxChar = '0;
    txEv = '0;
  end
  // one whole character per strobe; data inverted once released
  task automatic send_char(input logic [7:0] d);
    @(posedge clk);
    rxChar <= '{valid: 1'b1, data: d};
    @(posedge clk);
    rxChar <= '{valid: 1'b0, data: ~d};
  endtask
  // events last one cycle; queueEmpty comes from the event, so idle wait ends on a tick unless it is set
  task automatic pulse(input ifsr_txev_type e);
    @(posedge clk);
    txEv <= e;
    @(posedge clk);
    txEv <= '0;
  endtask
endmodule

//--- sim/inband_flow_status_recog_enable_test.sv
`timescale 1ns/1ps
module inband_flow_status_recog_enable_test import ifsr_pkg::*; ;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic txHalt, watchdogEn, addrMatchEn, autoRxFlowEn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ifsr_rxchar_type rxChar;
  ifsr_txev_type txEv;
  int num_errors = 0;
  int comparisons = 0;
  ifsr_top ifsr_top_i(.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxChar(rxChar), .txEv(txEv), .txHalt(txHalt), .watchdogEn(watchdogEn),
    .addrMatchEn(addrMatchEn), .autoRxFlowEn(autoRxFlowEn));
  ifsr_partner ifsr_partner_i(.clk(clk), .rxChar(rxChar), .txEv(txEv));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // no fixed latency assumed; bounded wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) num_errors++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, exp});
  endtask
  task automatic test_reset;
    rdchk(ADDR_RESUME_CHAR, 8'h11);
    rdchk(ADDR_PAUSE_CHAR, 8'h13);
    rdchk(ADDR_RECOG_ENABLE, 8'h00);
    rdchk(ADDR_FLOW_STATUS, 8'h00);
    rdchk(12'h01C, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_recog;
    wr(ADDR_RECOG_ENABLE, 8'h05);
    ifsr_partner_i.send_char(8'h13);
    rdchk(ADDR_FLOW_STATUS, 8'h40);
    rdchk(ADDR_FLOW_STATUS, 8'h00);
    ifsr_partner_i.send_char(8'h12);
    ifsr_partner_i.send_char(8'h93);
    rdchk(ADDR_FLOW_STATUS, 8'h00);
    ifsr_partner_i.send_char(8'h11);
    ifsr_partner_i.send_char(8'h13);
    rdchk(ADDR_MODE_ZERO, 8'h00);
    rdchk(ADDR_FLOW_STATUS, 8'hC0);
    rdchk(ADDR_INT_STATUS, 8'h03);
    chk({30'h0, autoRxFlowEn, txHalt}, 32'h0);
    wr(ADDR_RECOG_ENABLE, 8'h08);
    ifsr_partner_i.send_char(8'h11);
    rdchk(ADDR_FLOW_STATUS, 8'h00);
    $display("test recognition done");
  endtask
  task automatic test_enables;
    wr(ADDR_RECOG_ENABLE, 8'h50);
    chk({30'h0, watchdogEn, addrMatchEn}, 32'h3);
    ifsr_partner_i.send_char(8'h00);
    rdchk(ADDR_INT_STATUS, 8'h07);
    wr(ADDR_INT_STATUS, 8'h07);
    rdchk(ADDR_INT_STATUS, 8'h00);
    chk({31'h0, pslverr}, 32'h0);
    rdchk(ADDR_MODE_ZERO, 8'h80);
    wr(ADDR_RECOG_ENABLE, 8'h30);
    chk({30'h0, watchdogEn, addrMatchEn}, 32'h2);
    wr(ADDR_MODE_ZERO, 8'h00);
    chk({31'h0, watchdogEn}, 32'h0);
    wr(ADDR_MODE_ZERO, 8'h80);
    wr(ADDR_RECOG_ENABLE, 8'hC0);
    chk({31'h0, watchdogEn}, 32'h0);
    $display("test enables done");
  endtask
  task automatic test_txflow;
    wr(ADDR_RECOG_ENABLE, 8'h05);
    wr(ADDR_MODE_THREE, 8'h80);
    ifsr_partner_i.send_char(8'h13);
    rdchk(ADDR_FLOW_STATUS, 8'h44);
    chk({31'h0, txHalt}, 32'h0);
    ifsr_partner_i.pulse('{charDone: 1'b1, default: 1'b0});
    rdchk(ADDR_FLOW_STATUS, 8'h0C);
    chk({31'h0, txHalt}, 32'h1);
    ifsr_partner_i.send_char(8'h11);
    rdchk(ADDR_FLOW_STATUS, 8'h88);
    rdchk(ADDR_FLOW_STATUS, 8'h00);
    $display("test transmit flow done");
  endtask
  task automatic test_txtype;
    wr(ADDR_MODE_THREE, 8'h00);
    ifsr_partner_i.pulse('{pauseCmd: 1'b1, default: 1'b0});
    rdchk(ADDR_FLOW_STATUS, 8'h00);
    wr(ADDR_MODE_THREE, 8'h04);
    ifsr_partner_i.pulse('{pauseCmd: 1'b1, default: 1'b0});
    rdchk(ADDR_FLOW_STATUS, 8'h02);
    ifsr_partner_i.pulse('{charDone: 1'b1, default: 1'b0});
    rdchk(ADDR_FLOW_STATUS, 8'h01);
    ifsr_partner_i.pulse('{bitTick: 1'b1, queueEmpty: 1'b1, default: 1'b0});
    rdchk(ADDR_FLOW_STATUS, 8'h01);
    ifsr_partner_i.pulse('{bitTick: 1'b1, default: 1'b0});
    rdchk(ADDR_FLOW_STATUS, 8'h00);
    ifsr_partner_i.pulse('{resumeCmd: 1'b1, default: 1'b0});
    rdchk(ADDR_FLOW_STATUS, 8'h03);
    $display("test transmit type done");
  endtask
  task automatic test_autosent;
    wr(ADDR_MODE_THREE, 8'h00);
    wr(ADDR_MODE_ZERO, 8'h08);
    chk({31'h0, autoRxFlowEn}, 32'h1);
    ifsr_partner_i.pulse('{sentPause: 1'b1, default: 1'b0});
    rdchk(ADDR_FLOW_STATUS, 8'h20);
    ifsr_partner_i.pulse('{sentResume: 1'b1, default: 1'b0});
    rdchk(ADDR_FLOW_STATUS, 8'h10);
    ifsr_partner_i.pulse('{sentPause: 1'b1, default: 1'b0});
    wr(ADDR_MODE_ZERO, 8'h00);
    rdchk(ADDR_FLOW_STATUS, 8'h00);
    // host resumes the far side itself after leaving auto mode
    ifsr_partner_i.pulse('{resumeCmd: 1'b1, default: 1'b0});
    $display("test auto sent done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // whole run is a few hundred cycles; generous margin
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run;
  end
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    test_reset;
    test_recog;
    test_enables;
    test_txflow;
    test_txtype;
    test_autosent;
    complete_run;
  end
endmodule
